// [lfgs_defines.svh]
// Register map, field positions, reset values and limits of the gear scaler.
// Assumes inclusion by bare name from the design and bench files.
`ifndef LFGS_DEFINES_SVH
`define LFGS_DEFINES_SVH
`define LFGS_A_CTRL 8'h00
`define LFGS_A_NUMER 8'h04
`define LFGS_A_DENOM 8'h08
`define LFGS_A_FILTER 8'h0C
`define LFGS_A_LRES 8'h10
`define LFGS_A_MRES 8'h14
`define LFGS_A_STAT 8'h18
`define LFGS_A_LCUM 8'h1C
`define LFGS_A_LINFO 8'h20
`define LFGS_A_MSCL 8'h24
`define LFGS_A_FUSED 8'h28
`define LFGS_B_POL 0
`define LFGS_B_ABZ 1
`define LFGS_RST_FILTER 13'h000A
`define LFGS_RST_ONE 32'h0000_0001
`define LFGS_FILT_MIN 13'h0001
`define LFGS_FILT_DUAL_MAX 13'h1193
`define LFGS_FILT_FULL 13'h1194
`define LFGS_RECIP 72'h00_0000_0000_000E_9045
`define LFGS_LIM_SHIFT 31
`define LFGS_ZERO32 32'h0000_0000
`endif

// [lfgs_encoder_model.sv]
// Partner model: motor and load encoders, one step pulse per count.
// Assumes the bench calls its tasks from the hclk domain.
`timescale 1ns/10ps
module lfgs_encoder_model (
  // Clock
  input wire logic hclk,
  // Encoder lines
  output lfgs_pkg::lfgs_motor_s motor,
  output lfgs_pkg::lfgs_load_s load
);
  int acc = 0;
  // Idle encoders: no step, no mark
  initial begin
    motor = '0;
    load = '0;
  end
  // Moves n motor counts; load steps follow at lnum/lden per count.
  // The remainder persists so split moves stay in ratio.
  task automatic move(input int n, input int lnum, input int lden, input logic mot);
    repeat (n) begin
      @(posedge hclk);
      acc += lnum;
      motor <= '{step: mot, ccw: 1'b1};
      load <= '{step: acc >= lden, dir: 1'b1, ref_mark: 1'b0};
      if (acc >= lden) begin
        acc -= lden;
      end
    end
    @(posedge hclk);
    motor.step <= 1'b0;
    load.step <= 1'b0;
  endtask
  // One-cycle pass over the reference mark
  task automatic mark();
    @(posedge hclk);
    load.ref_mark <= 1'b1;
    @(posedge hclk);
    load.ref_mark <= 1'b0;
  endtask
endmodule

// [lfgs_pkg.sv]
// Types shared by the load feedback gear scaler.
// Encoder inputs are synchronous single-cycle step pulses.
package lfgs_pkg;
  typedef struct packed {
    logic step;
    logic ccw;
  } lfgs_motor_s;
  typedef struct packed {
    logic step;
    logic dir;
    logic ref_mark;
  } lfgs_load_s;
  typedef enum logic [1:0] {LFGS_IDLE, LFGS_GCD, LFGS_CMP} lfgs_chk_e;
endpackage

// [lfgs_scaler.sv]
// Load feedback gear scaler: AHB-Lite registers, gear check, counters.
// Assumes one hclk domain and synchronous encoder step pulses.
// Operation
// - Reduced gear fraction terms above 2147483647 raise the parameter alarm.
// - Skip that check for differential ABZ encoder with resolution zero.
// - Filter 1 to 4499 selects dual feedback; 4500 selects fully closed.
// - Filter setting resets to 10.
// - Larger filter weights load-side feedback more in fused position.
// - Differential ABZ resolution zero means linear, nonzero means rotary.
// - Load-side pulses accumulate into a readable cumulative count.
// - Load info word clears to zero at the reference mark.
// - Motor pulses scale by numerator over denominator.
// - Polarity zero counts up for CCW, one counts down.
`timescale 1ns/10ps
`include "lfgs_defines.svh"
module lfgs_scaler (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Encoders
  input wire lfgs_pkg::lfgs_motor_s motor,
  input wire lfgs_pkg::lfgs_load_s load,
  // Status
  output logic parameter_error_alarm,
  output logic dual_mode,
  output logic fully_closed_mode,
  output logic rotary_encoder
);
  logic load_count_polarity, abz_differential;
  logic [31:0] feedback_gear_numerator, feedback_gear_denominator;
  logic [12:0] dual_feedback_filter;
  logic [31:0] load_encoder_resolution, motor_resolution;
  logic [31:0] load_cum, load_info, motor_scaled, fused_pos;
  logic signed [63:0] rem;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic check_req, gear_alarm, filt_written;
  lfgs_pkg::lfgs_chk_e chk;
  logic [63:0] num, den, ga, gb;
  logic [6:0] gk;
  logic addr_ok;
  logic [31:0] next_rdata;

  function automatic logic filt_dual(input logic [12:0] f);
    filt_dual = (f >= `LFGS_FILT_MIN) && (f <= `LFGS_FILT_DUAL_MAX);
  endfunction

  // Address phase is taken only when the bus is ready and a transfer is real
  assign addr_ok = hsel && htrans[1] && hready;

  // Bus handshake: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    next_rdata = `LFGS_ZERO32;
    unique case (haddr[7:0])
      `LFGS_A_CTRL: begin
        next_rdata[`LFGS_B_POL] = load_count_polarity;
        next_rdata[`LFGS_B_ABZ] = abz_differential;
      end
      `LFGS_A_NUMER: next_rdata = feedback_gear_numerator;
      `LFGS_A_DENOM: next_rdata = feedback_gear_denominator;
      `LFGS_A_FILTER: next_rdata = {19'h00000, dual_feedback_filter};
      `LFGS_A_LRES: next_rdata = load_encoder_resolution;
      `LFGS_A_MRES: next_rdata = motor_resolution;
      `LFGS_A_STAT: next_rdata = {27'h0000000, rotary_encoder,
        check_req || chk != lfgs_pkg::LFGS_IDLE, fully_closed_mode, dual_mode,
        parameter_error_alarm};
      `LFGS_A_LCUM: next_rdata = load_cum;
      `LFGS_A_LINFO: next_rdata = load_info;
      `LFGS_A_MSCL: next_rdata = motor_scaled;
      `LFGS_A_FUSED: next_rdata = fused_pos;
      default: next_rdata = `LFGS_ZERO32;
    endcase
  end

  // Read data is latched at the address phase so it leaves a flip-flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `LFGS_ZERO32;
    end else if (addr_ok && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // Setting registers, written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_count_polarity <= 1'b0;
      abz_differential <= 1'b0;
      feedback_gear_numerator <= `LFGS_RST_ONE;
      feedback_gear_denominator <= `LFGS_RST_ONE;
      dual_feedback_filter <= `LFGS_RST_FILTER;
      load_encoder_resolution <= `LFGS_ZERO32;
      motor_resolution <= `LFGS_RST_ONE;
      filt_written <= 1'b0;
    end else if (wr_pend) begin
      unique case (wr_addr)
        `LFGS_A_CTRL: begin
          load_count_polarity <= hwdata[`LFGS_B_POL];
          abz_differential <= hwdata[`LFGS_B_ABZ];
        end
        `LFGS_A_NUMER: feedback_gear_numerator <= hwdata;
        `LFGS_A_DENOM: feedback_gear_denominator <= hwdata;
        `LFGS_A_FILTER: begin
          dual_feedback_filter <= hwdata[12:0];
          filt_written <= 1'b1;
        end
        `LFGS_A_LRES: load_encoder_resolution <= hwdata;
        `LFGS_A_MRES: motor_resolution <= hwdata;
        default: ;
      endcase
    end
  end

  // Gear terms before reduction
  assign num = 64'(feedback_gear_numerator) * 64'(motor_resolution);
  assign den = 64'(feedback_gear_denominator) * 64'(load_encoder_resolution);

  // Any gear-related write restarts the check; a new request wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      check_req <= 1'b1;
    end else if (wr_pend && wr_addr != `LFGS_A_FILTER) begin
      check_req <= 1'b1;
    end else if (chk == lfgs_pkg::LFGS_IDLE) begin
      check_req <= 1'b0;
    end
  end

  // Binary gcd, then term > limit*gcd, which avoids a divider
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chk <= lfgs_pkg::LFGS_IDLE;
      ga <= 64'h0;
      gb <= 64'h0;
      gk <= 7'h00;
      gear_alarm <= 1'b0;
    end else begin
      unique case (chk)
        lfgs_pkg::LFGS_IDLE: if (check_req) begin
          if (abz_differential && load_encoder_resolution == `LFGS_ZERO32) begin
            gear_alarm <= 1'b0;
          end else if (num == 64'h0 || den == 64'h0) begin
            gear_alarm <= 1'b1;
          end else begin
            ga <= num;
            gb <= den;
            gk <= 7'h00;
            chk <= lfgs_pkg::LFGS_GCD;
          end
        end
        lfgs_pkg::LFGS_GCD: begin
          if (ga == gb) chk <= lfgs_pkg::LFGS_CMP;
          else if (!ga[0] && !gb[0]) begin
            ga <= ga >> 1;
            gb <= gb >> 1;
            gk <= gk + 7'h01;
          end else if (!ga[0]) ga <= ga >> 1;
          else if (!gb[0]) gb <= gb >> 1;
          else if (ga > gb) ga <= (ga - gb) >> 1;
          else gb <= (gb - ga) >> 1;
        end
        lfgs_pkg::LFGS_CMP: begin
          gear_alarm <= (96'(num) > ((96'(ga) << gk) << `LFGS_LIM_SHIFT) - (96'(ga) << gk))
            || (96'(den) > ((96'(ga) << gk) << `LFGS_LIM_SHIFT) - (96'(ga) << gk));
          chk <= lfgs_pkg::LFGS_IDLE;
        end
      endcase
    end
  end

  // Mode decode and alarm outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dual_mode <= 1'b0;
      fully_closed_mode <= 1'b0;
      parameter_error_alarm <= 1'b0;
      rotary_encoder <= 1'b0;
    end else begin
      dual_mode <= filt_dual(dual_feedback_filter);
      fully_closed_mode <= dual_feedback_filter == `LFGS_FILT_FULL;
      parameter_error_alarm <= gear_alarm || !(filt_dual(dual_feedback_filter)
        || dual_feedback_filter == `LFGS_FILT_FULL);
      rotary_encoder <= !abz_differential || load_encoder_resolution != `LFGS_ZERO32;
    end
  end

  // Load-side counters; the reference mark clears the info word over a step
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_cum <= `LFGS_ZERO32;
      load_info <= `LFGS_ZERO32;
    end else begin
      if (load.step) begin
        load_cum <= (load.dir ^ load_count_polarity) ? load_cum + 32'h1
          : load_cum - 32'h1;
      end
      if (load.ref_mark) load_info <= `LFGS_ZERO32;
      else if (load.step) begin
        load_info <= (load.dir ^ load_count_polarity) ? load_info + 32'h1 : load_info - 32'h1;
      end
    end
  end

  // Scaler: one carry per cycle keeps the remainder, so no drift builds up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rem <= 64'sh0;
      motor_scaled <= `LFGS_ZERO32;
    end else begin
      if (rem >= $signed(64'(feedback_gear_denominator))) begin
        rem <= rem - $signed(64'(feedback_gear_denominator))
          + (motor.step ? (motor.ccw ? $signed(64'(feedback_gear_numerator))
          : -$signed(64'(feedback_gear_numerator))) : 64'sh0);
        motor_scaled <= motor_scaled + 32'h1;
      end else if (rem < 64'sh0) begin
        rem <= rem + $signed(64'(feedback_gear_denominator))
          + (motor.step ? (motor.ccw ? $signed(64'(feedback_gear_numerator))
          : -$signed(64'(feedback_gear_numerator))) : 64'sh0);
        motor_scaled <= motor_scaled - 32'h1;
      end else if (motor.step) begin
        rem <= rem + (motor.ccw ? $signed(64'(feedback_gear_numerator))
          : -$signed(64'(feedback_gear_numerator)));
      end
    end
  end

  // Fused position: motor side plus filter/4500 of the load-side deviation
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fused_pos <= `LFGS_ZERO32;
    end else if (fully_closed_mode) begin
      fused_pos <= load_cum;
    end else begin
      fused_pos <= motor_scaled + 32'(($signed(72'($signed(load_cum - motor_scaled)))
        * $signed(72'(dual_feedback_filter)) * $signed(`LFGS_RECIP)) >>> 32);
    end
  end

  sequence chk_start_s;
    chk == lfgs_pkg::LFGS_IDLE && check_req;
  endsequence
  sequence chk_done_s;
    chk == lfgs_pkg::LFGS_IDLE && !check_req;
  endsequence

  filt_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !filt_written |-> dual_feedback_filter == `LFGS_RST_FILTER) else $error("filter default lost");
  // Sampled reset gates the start, so the edge at which reset lets go is not judged
  mode_decode_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn |=> (dual_mode == filt_dual($past(dual_feedback_filter)))
    && (fully_closed_mode == ($past(dual_feedback_filter) == `LFGS_FILT_FULL)))
    else $error("mode decode wrong");
  info_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    load.ref_mark |=> load_info == `LFGS_ZERO32) else $error("info word not cleared");
  count_dir_a: assert property (@(posedge hclk) disable iff (!hresetn)
    load.step |=> load_cum == ($past(load.dir ^ load_count_polarity) ? $past(load_cum) + 32'h1
    : $past(load_cum) - 32'h1)) else $error("load count direction wrong");
  scale_carry_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rem >= $signed(64'(feedback_gear_denominator)) |=> motor_scaled == $past(motor_scaled) + 32'h1)
    else $error("scaler carry missed");
  check_bound_a: assert property (@(posedge hclk) disable iff (!hresetn)
    chk_start_s |-> ##[1:300] chk_done_s) else $error("gear check too slow");
  skip_check_a: assert property (@(posedge hclk) disable iff (!hresetn)
    chk_start_s ##0 (abz_differential && load_encoder_resolution == `LFGS_ZERO32)
    |=> !gear_alarm) else $error("check not skipped");
  fused_full_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fully_closed_mode |=> fused_pos == $past(load_cum)) else $error("fused not load side");
endmodule

// [lfgs_scaler_bench.sv]
// Bench for the gear scaler: AHB-Lite tasks and scenario sequence.
// Assumes the design, its package and the encoder model compile first.
`timescale 1ns/10ps
`include "lfgs_defines.svh"
module lfgs_scaler_bench;
  logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, cum0, scl0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, alarm, dual, full, rotary;
  logic [31:0] fv [4] = '{32'h1, 32'h1193, 32'h1194, 32'hA};
  logic [1:0] fm [4] = '{2'h2, 2'h2, 2'h1, 2'h2};
  lfgs_pkg::lfgs_motor_s motor;
  lfgs_pkg::lfgs_load_s load;
  int failures = 0, total_checks = 0, cycles = 0;
  lfgs_scaler i_lfgs_scaler (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .motor(motor), .load(load),
    .parameter_error_alarm(alarm), .dual_mode(dual), .fully_closed_mode(full),
    .rotary_encoder(rotary));
  lfgs_encoder_model i_lfgs_encoder_model (.hclk(hclk), .motor(motor), .load(load));
  // 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Hang guard; the sequence needs well under a thousand cycles
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // Address phase held until hready is sampled high
  task automatic aphase(input logic [7:0] a, input logic w);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    aphase(a, 1'b1);
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  task automatic rdr(input logic [7:0] a);
    aphase(a, 1'b0);
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "response");
  endtask
  // Writes a gear setup, waits out the check, compares the alarm
  task automatic gear(input logic [31:0] nu, mr, de, lr, input logic [1:0] ct, input logic al);
    int n;
    n = 0;
    wr(`LFGS_A_CTRL, {30'h0, ct});
    wr(`LFGS_A_NUMER, nu);
    wr(`LFGS_A_MRES, mr);
    wr(`LFGS_A_DENOM, de);
    wr(`LFGS_A_LRES, lr);
    repeat (4) @(posedge hclk);
    do begin
      rdr(`LFGS_A_STAT);
      n++;
    end while (rd[3] === 1'b1 && n < 200);
    chk({31'h0, rd[3]}, 32'h0, "check busy");
    chk({31'h0, alarm}, {31'h0, al}, "alarm");
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdr(`LFGS_A_FILTER);
    chk(rd, {19'h0, `LFGS_RST_FILTER}, "filter reset");
    chk({31'h0, dual}, 32'h1, "dual after reset");
    rdr(8'h40);
    chk(rd, 32'h0, "unmapped read");
    $display("test reset done");
    // Loop gain assumed at least twice each filter value used here
    foreach (fv[i]) begin
      wr(`LFGS_A_FILTER, fv[i]);
      repeat (2) @(posedge hclk);
      chk({30'h0, dual, full}, {30'h0, fm[i]}, "mode");
    end
    $display("test modes done");
    gear(32'h3, 32'h4000000, 32'h2, 32'h4000000, 2'h0, 1'b0);
    gear(32'h7FFFFFFF, 32'h1, 32'h1, 32'h1, 2'h0, 1'b0);
    gear(32'h7FFFFFFF, 32'h2, 32'h1, 32'h1, 2'h0, 1'b1);
    gear(32'h7FFFFFFF, 32'h2, 32'h2, 32'h1, 2'h0, 1'b0);
    gear(32'h7FFFFFFF, 32'h2, 32'h1, 32'h1, 2'h2, 1'b1);
    gear(32'h7FFFFFFF, 32'h2, 32'h1, 32'h0, 2'h2, 1'b0);
    chk({31'h0, rotary}, 32'h0, "linear type");
    wr(`LFGS_A_LRES, 32'h3E8);
    repeat (2) @(posedge hclk);
    chk({31'h0, rotary}, 32'h1, "rotary type");
    $display("test gear done");
    gear(32'h1, 32'h1, 32'h2, 32'h1, 2'h0, 1'b0);
    rdr(`LFGS_A_LCUM);
    cum0 = rd;
    rdr(`LFGS_A_MSCL);
    scl0 = rd;
    // Split bursts leave remainders that must carry across
    i_lfgs_encoder_model.move(3, 1, 2, 1'b1);
    i_lfgs_encoder_model.move(3, 1, 2, 1'b1);
    i_lfgs_encoder_model.move(4, 1, 2, 1'b1);
    repeat (8) @(posedge hclk);
    rdr(`LFGS_A_LCUM);
    chk(rd - cum0, 32'h5, "load count");
    cum0 = rd;
    rdr(`LFGS_A_MSCL);
    chk(rd - scl0, 32'h5, "scaled motor");
    wr(`LFGS_A_CTRL, 32'h1);
    i_lfgs_encoder_model.move(4, 1, 1, 1'b0);
    rdr(`LFGS_A_LCUM);
    chk(cum0 - rd, 32'h4, "reversed count");
    cum0 = rd;
    wr(`LFGS_A_FILTER, 32'h1194);
    repeat (2) @(posedge hclk);
    rdr(`LFGS_A_FUSED);
    chk(rd, cum0, "fused fully closed");
    // Five steps up then four down leave the info word at one before the mark
    rdr(`LFGS_A_LINFO);
    chk(rd, 32'h1, "info before mark");
    i_lfgs_encoder_model.mark();
    repeat (2) @(posedge hclk);
    rdr(`LFGS_A_LINFO);
    chk(rd, 32'h0, "info cleared");
    $display("test counts done");
    summarize();
  end
endmodule
